// ===== ncs_top.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Function
// RULE_01: Move destination stays on source die.
// RULE_02: Move read is 00h, four addresses, 35h.
// RULE_03: Device loads cache, ignores column bits.
// RULE_04: Move program only after ready returns.
// RULE_05: Device programs; status 6 and 0 report.
// RULE_06: Column reposition 85h repeatable before 10h.
// RULE_07: Use two-bit ECC with page moves.
// RULE_08: Erase hits one of 1,024 blocks.
// RULE_09: Erase takes two block address cycles.
// RULE_10: Erase is 60h, two addresses, D0h.
// RULE_11: Device busy through erase and verify.
// RULE_12: Erase status bit 6 done, bit 0.
// RULE_13: Ten one-time pages, numbers 02h to 0Bh.
// RULE_14: One-time pages only clear bits, four partials.
// RULE_15: One-time program A0h, addresses, data, 10h.
// RULE_16: Protected area rejects program, bit 7 low.
// RULE_17: 85h in one-time program only unprotected.
// RULE_18: Only 70h while one-time op busy.
// RULE_19: Protect is A5h, 00h 00h 01h 00h, 10h.
// RULE_20: Protection permanent, about one program time.
// RULE_21: One-time read AFh, four addresses, 30h.
// RULE_22: Reset after one-time read, within 5 us.
// RULE_23: Device ignores other commands while busy.
module ncs_top (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // NAND pins
   output logic             cle_o,
   output logic             ale_o,
   output logic             ce_n_o,
   output logic             we_n_o,
   output logic             re_n_o,
   output logic      [7:0]  io_o,
   output logic             io_oe_n_o,
   input  wire logic [7:0]  io_i,
   input  wire logic        rb_n_i
);
   import ncs_pkg::*;

   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_SEQ  = 8'b0000_0010,
      ST_DATA = 8'b0000_0100,
      ST_TWB  = 8'b0000_1000,
      ST_WAIT = 8'b0001_0000,
      ST_STC  = 8'b0010_0000,
      ST_STR  = 8'b0100_0000,
      ST_RWT  = 8'b1000_0000
   } ncs_state_type;

   ncs_state_type state_q, state_d;
   logic [31:0] ctrl, addr, stat;
   logic [7:0]  wdata, rbyte;
   logic        go, wdata_wr, rdata_rd;
   logic [2:0]  op_q;
   logic [3:0]  step_q, nsteps;
   logic [11:0] len_q, cnt_q;
   logic [7:0]  sr_q, rdata_q;
   logic        dreq_q, err_q, bc_req, bc_done;
   logic [1:0]  bc_kind;
   logic [7:0]  bc_byte;
   logic [7:0]  rst_cnt_q;
   logic [2:0]  twb_q;
   logic        die_q;
   logic        busy, otp_op, page_ok, need_status, last_step;

   ncs_apb_regs u_regs (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .psel_i     (psel_i),
      .penable_i  (penable_i),
      .pwrite_i   (pwrite_i),
      .paddr_i    (paddr_i),
      .pwdata_i   (pwdata_i),
      .prdata_o   (prdata_o),
      .pready_o   (pready_o),
      .pslverr_o  (pslverr_o),
      .ctrl_o     (ctrl),
      .addr_o     (addr),
      .wdata_o    (wdata),
      .go_o       (go),
      .wdata_wr_o (wdata_wr),
      .rdata_rd_o (rdata_rd),
      .stat_i     (stat),
      .rdata_i    (rdata_q)
   );

   ncs_bus_cycle u_cyc (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .req_i     (bc_req),
      .kind_i    (bc_kind),
      .byte_i    (bc_byte),
      .done_o    (bc_done),
      .rbyte_o   (rbyte),
      .cle_o     (cle_o),
      .ale_o     (ale_o),
      .we_n_o    (we_n_o),
      .re_n_o    (re_n_o),
      .io_o      (io_o),
      .io_oe_n_o (io_oe_n_o),
      .io_i      (io_i)
   );

   assign ce_n_o = 1'b0;
   assign busy   = (state_q != ST_IDLE);
   assign stat   = {16'h0000, sr_q, 5'h00, err_q, dreq_q, busy};
   assign otp_op = (op_q == OP_OTP_PROG) | (op_q == OP_OTP_READ);
   // One-time page number must be 02h..0Bh
   assign page_ok = (addr[21:16] >= OTP_PAGE_MIN) && (addr[21:16] <= OTP_PAGE_MAX); // RULE_13

   // Steps of each sequence: cmd/addr bytes before data or wait
   function automatic logic [3:0] ncs_steps(input logic [2:0] op);
      unique case (op)
         OP_MOVE_RD, OP_OTP_READ, OP_MOVE_PROG, OP_OTP_PROG, OP_OTP_PROT: ncs_steps = 4'd5;
         OP_ERASE:  ncs_steps = 4'd3;
         OP_COL_IN: ncs_steps = 4'd3;
         OP_RESET:  ncs_steps = 4'd1;
         default:   ncs_steps = 4'd1;
      endcase
   endfunction
   assign nsteps = ncs_steps(op_q);
   assign last_step = (step_q == nsteps - 4'd1);

   // Byte and kind for each step
   always_comb begin
      bc_kind = 2'd1;
      bc_byte = 8'h00;
      if (state_q == ST_SEQ) begin
         if (step_q == 4'd0) begin
            bc_kind = 2'd0;
            unique case (op_q)
               OP_MOVE_RD:   bc_byte = CMD_READ;      // RULE_02
               OP_MOVE_PROG: bc_byte = CMD_COL_IN;    // RULE_04 RULE_07
               OP_COL_IN:    bc_byte = CMD_COL_IN;    // RULE_06
               OP_ERASE:     bc_byte = CMD_ERASE;     // RULE_10
               OP_OTP_PROG:  bc_byte = CMD_OTP_PROG;  // RULE_15
               OP_OTP_PROT:  bc_byte = CMD_OTP_PROT;  // RULE_19
               OP_OTP_READ:  bc_byte = CMD_OTP_READ;  // RULE_21
               default:      bc_byte = CMD_RESET;     // RULE_22
            endcase
         end else if (op_q == OP_ERASE) begin
            // Two block cycles; page bits sent as given
            bc_byte = (step_q == 4'd1) ? addr[23:16] : addr[31:24]; // RULE_09
         end else if (op_q == OP_OTP_PROT) begin
            bc_byte = (step_q == 4'd3) ? PROT_A2 : 8'h00; // RULE_19
         end else begin
            unique case (step_q)
               4'd1:    bc_byte = addr[7:0];
               4'd2:    bc_byte = addr[15:8];
               4'd3:    bc_byte = addr[23:16];
               default: bc_byte = addr[31:24];
            endcase
         end
      end else if (state_q == ST_DATA) begin
         bc_kind = (op_q == OP_OTP_READ) ? 2'd3 : 2'd2;
         bc_byte = wdata;
      end else if (state_q == ST_STC) begin
         bc_kind = 2'd0;
         bc_byte = CMD_STATUS;                         // RULE_18
      end else if (state_q == ST_STR) begin
         bc_kind = 2'd3;
      end else if (state_q == ST_TWB) begin
         bc_kind = 2'd0;
         unique case (op_q)
            OP_MOVE_RD:  bc_byte = CMD_MOVE_RD;        // RULE_02
            OP_ERASE:    bc_byte = CMD_ERASE_CF;       // RULE_10
            OP_OTP_READ: bc_byte = CMD_READ_CF;        // RULE_21
            default:     bc_byte = CMD_PROG;           // RULE_15
         endcase
      end
   end

   // Data phase: programs carry bytes, only the one-time read fetches bytes
   assign need_status = (op_q != OP_MOVE_RD) && (op_q != OP_OTP_READ) && (op_q != OP_RESET);
   assign bc_req = ((state_q == ST_SEQ) || (state_q == ST_STC) || (state_q == ST_STR)
                    || (state_q == ST_TWB && twb_q == 3'd0)
                    || (state_q == ST_DATA && dreq_q))
                   && !bc_done;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (go) state_d = ST_SEQ;
         ST_SEQ:  if (bc_done && last_step)
                     state_d = (op_q == OP_RESET) ? ST_RWT :
                               (len_q != 12'h000 && op_q != OP_OTP_READ) ? ST_DATA : ST_TWB;
         ST_DATA: if (bc_done && cnt_q == len_q - 12'h001)
                     state_d = (op_q == OP_OTP_READ || op_q == OP_COL_IN) ? ST_IDLE : ST_TWB;
         ST_TWB:  if (bc_done) state_d = ST_WAIT;
         ST_WAIT: if (rb_n_i && twb_q == 3'(TWB_CYC))
                     state_d = need_status ? ST_STC : (op_q == OP_OTP_READ && len_q != 12'h000)
                               ? ST_DATA : ST_IDLE;
         ST_STC:  if (bc_done) state_d = ST_STR;
         ST_STR:  if (bc_done) state_d = ST_IDLE;
         ST_RWT:  if (rst_cnt_q == 8'(RESET_CYC) || (rb_n_i && twb_q == 3'(TWB_CYC)))
                     state_d = ST_IDLE;                // RULE_22
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         op_q <= OP_RESET;
         step_q <= 4'h0;
         len_q <= 12'h000;
         cnt_q <= 12'h000;
         sr_q <= 8'h00;
         rdata_q <= 8'h00;
         dreq_q <= 1'b0;
         err_q <= 1'b0;
         die_q <= 1'b0;
         rst_cnt_q <= 8'h00;
         twb_q <= 3'h0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE && go) begin
            op_q <= ctrl[CTRL_OP_LSB +: 3];
            len_q <= ctrl[CTRL_LEN_LSB +: 12];
            step_q <= 4'h0;
            cnt_q <= 12'h000;
            rst_cnt_q <= 8'h00;
            twb_q <= 3'h0;
            dreq_q <= 1'b0;
            err_q <= (ctrl[CTRL_OP_LSB +: 3] == OP_OTP_PROG ||
                      ctrl[CTRL_OP_LSB +: 3] == OP_OTP_READ) && !page_ok;
            if (ctrl[CTRL_LEN_LSB +: 12] > PAGE_BYTES) err_q <= 1'b1; // RULE_15
            // Move program must target the die of the move read
            if (ctrl[CTRL_OP_LSB +: 3] == OP_MOVE_RD) die_q <= addr[ADDR_DIE_BIT];
            if (ctrl[CTRL_OP_LSB +: 3] == OP_MOVE_PROG && addr[ADDR_DIE_BIT] != die_q) begin
               err_q <= 1'b1; // RULE_01
            end
         end
         if (state_q == ST_SEQ && bc_done) step_q <= step_q + 4'h1;
         // Data byte may arrive before the data phase; it waits as pending
         if (state_q == ST_DATA && bc_done) begin
            cnt_q <= cnt_q + 12'h001;
            dreq_q <= wdata_wr | rdata_rd;
            if (op_q == OP_OTP_READ) rdata_q <= rbyte;
         end else if (busy && (wdata_wr || rdata_rd)) begin
            dreq_q <= 1'b1;
         end
         if (state_q == ST_TWB && bc_done) twb_q <= 3'h0;
         else if ((state_q == ST_WAIT || state_q == ST_RWT) && twb_q != 3'(TWB_CYC))
            twb_q <= twb_q + 3'h1;
         if (state_q == ST_RWT && rst_cnt_q != 8'(RESET_CYC)) rst_cnt_q <= rst_cnt_q + 8'h01;
         if (state_q == ST_STR && bc_done) begin
            sr_q <= rbyte;                             // RULE_05
            err_q <= err_q | rbyte[SR_PASS_BIT]        // RULE_12
                   | ((op_q == OP_OTP_PROG) & ~rbyte[SR_WP_BIT]); // RULE_16
         end
      end
   end

   // Post-command wait (ST_WAIT) is never cut short while ready/busy is low; the reset wait ends at RESET_CYC even if busy
   property p_wait_busy;
      @(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_WAIT && !rb_n_i) |=> (state_q == ST_WAIT);
   endproperty
   a_wait_on_busy: assert property (p_wait_busy) else $error("left wait while busy"); // RULE_11

   sequence s_status_cmd;
      (state_q == ST_STC && bc_byte == CMD_STATUS && bc_kind == 2'd0) ##1 (state_q == ST_STC);
   endsequence
   a_status_after_prog: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_WAIT && state_d == ST_STC) |=> s_status_cmd)
      else $error("status command not issued"); // RULE_18

   a_move_second_cmd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_TWB && op_q == OP_MOVE_RD) |-> (bc_byte == CMD_MOVE_RD))
      else $error("move read confirm wrong"); // RULE_02

   a_erase_two_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_SEQ && op_q == OP_ERASE) |-> (step_q <= 4'd2))
      else $error("erase address count wrong"); // RULE_10

   a_reset_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_RWT) |-> (rst_cnt_q <= 8'(RESET_CYC)))
      else $error("reset wait overran"); // RULE_22

   a_prot_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_SEQ && op_q == OP_OTP_PROT && step_q == 4'd3) |-> (bc_byte == PROT_A2))
      else $error("protect address wrong"); // RULE_19

   a_otp_page_err: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_IDLE && go && ctrl[2:0] == OP_OTP_PROG && !page_ok) |=> err_q)
      else $error("bad one-time page not flagged"); // RULE_13

   a_pin_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_IDLE) |-> (we_n_o && re_n_o))
      else $error("strobe active while idle"); // RULE_23
endmodule

// ===== ncs_pkg.sv
package ncs_pkg;
   // NAND command bytes
   localparam logic [7:0] CMD_READ      = 8'h00;
   localparam logic [7:0] CMD_MOVE_RD   = 8'h35;
   localparam logic [7:0] CMD_COL_IN    = 8'h85;
   localparam logic [7:0] CMD_PROG      = 8'h10;
   localparam logic [7:0] CMD_ERASE     = 8'h60;
   localparam logic [7:0] CMD_ERASE_CF  = 8'hD0;
   localparam logic [7:0] CMD_OTP_PROG  = 8'hA0;
   localparam logic [7:0] CMD_OTP_PROT  = 8'hA5;
   localparam logic [7:0] CMD_OTP_READ  = 8'hAF;
   localparam logic [7:0] CMD_READ_CF   = 8'h30;
   localparam logic [7:0] CMD_STATUS    = 8'h70;
   localparam logic [7:0] CMD_RESET     = 8'hFF;
   localparam logic [7:0] CMD_RCOL      = 8'h05;
   localparam logic [7:0] CMD_RCOL_CF   = 8'hE0;
   // Operation codes written to the control register
   localparam logic [2:0] OP_MOVE_RD    = 3'h1;
   localparam logic [2:0] OP_MOVE_PROG  = 3'h2;
   localparam logic [2:0] OP_COL_IN     = 3'h3;
   localparam logic [2:0] OP_ERASE      = 3'h4;
   localparam logic [2:0] OP_OTP_PROG   = 3'h5;
   localparam logic [2:0] OP_OTP_PROT   = 3'h6;
   localparam logic [2:0] OP_OTP_READ   = 3'h7;
   localparam logic [2:0] OP_RESET      = 3'h0;
   // Register offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_ADDR      = 8'h04;
   localparam logic [7:0] REG_DATA      = 8'h08;
   localparam logic [7:0] REG_STAT      = 8'h0C;
   localparam logic [7:0] REG_RDATA     = 8'h10;
   // Control fields
   localparam int CTRL_OP_LSB    = 0;
   localparam int CTRL_GO_BIT    = 4;
   localparam int CTRL_LEN_LSB   = 16;
   // Status fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DREQ_BIT  = 1;
   localparam int STAT_SR_LSB    = 8;
   localparam int STAT_ERR_BIT   = 2;
   localparam int SR_PASS_BIT    = 0;
   localparam int SR_RDY_BIT     = 6;
   localparam int SR_WP_BIT      = 7;
   // Geometry
   localparam logic [5:0] OTP_PAGE_MIN  = 6'h02;
   localparam logic [5:0] OTP_PAGE_MAX  = 6'h0B;
   localparam logic [11:0] PAGE_BYTES   = 12'h840;
   localparam logic [31:0] RST_ADDR     = 32'h0000_0000;
   localparam logic [7:0] PROT_A2       = 8'h01;
   localparam int ADDR_DIE_BIT   = 31;
   // Timing: strobe phases and reset wait
   localparam int CLK_MHZ        = 25;
   localparam int STROBE_NS      = 40;
   localparam int STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_US       = 5;
   localparam int RESET_CYC      = RESET_US * CLK_MHZ;
   localparam int TWB_CYC        = 3;
endpackage

// ===== ncs_apb_regs.sv
`timescale 1ns/1ps
module ncs_apb_regs (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Register contents
   output logic      [31:0] ctrl_o,
   output logic      [31:0] addr_o,
   output logic      [7:0]  wdata_o,
   output logic             go_o,
   output logic             wdata_wr_o,
   output logic             rdata_rd_o,
   input  wire logic [31:0] stat_i,
   input  wire logic [7:0]  rdata_i
);
   import ncs_pkg::*;
   logic [31:0] ctrl_q, addr_q;
   logic [7:0]  wdata_q;
   logic        acc, wr, rd, hit;
   assign acc = psel_i & penable_i;
   assign wr  = acc & pwrite_i;
   assign rd  = acc & ~pwrite_i;
   assign hit = (paddr_i == REG_CTRL) | (paddr_i == REG_ADDR) | (paddr_i == REG_DATA)
              | (paddr_i == REG_STAT) | (paddr_i == REG_RDATA);
   assign pready_o   = 1'b1;
   assign pslverr_o  = acc & ~hit;
   // Written word is seen in the same cycle as its go strobe
   assign ctrl_o     = (wr && paddr_i == REG_CTRL) ? pwdata_i : ctrl_q;
   assign addr_o     = addr_q;
   assign wdata_o    = wdata_q;
   assign go_o       = wr & (paddr_i == REG_CTRL) & pwdata_i[CTRL_GO_BIT];
   assign wdata_wr_o = wr & (paddr_i == REG_DATA);
   assign rdata_rd_o = rd & (paddr_i == REG_RDATA);
   assign prdata_o   = (paddr_i == REG_CTRL)  ? ctrl_q :
                       (paddr_i == REG_ADDR)  ? addr_q :
                       (paddr_i == REG_DATA)  ? {24'h000000, wdata_q} :
                       (paddr_i == REG_STAT)  ? stat_i :
                       (paddr_i == REG_RDATA) ? {24'h000000, rdata_i} : 32'h0000_0000;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_q  <= 32'h0000_0000;
         addr_q  <= 32'h0000_0000;
         wdata_q <= 8'h00;
      end else begin
         if (wr && paddr_i == REG_CTRL) ctrl_q <= pwdata_i;
         if (wr && paddr_i == REG_ADDR) addr_q <= pwdata_i;
         if (wdata_wr_o) wdata_q <= pwdata_i[7:0];
      end
   end
endmodule

// ===== ncs_bus_cycle.sv
`timescale 1ns/1ps
module ncs_bus_cycle (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   // Request
   input  wire logic       req_i,
   input  wire logic [1:0] kind_i,
   input  wire logic [7:0] byte_i,
   output logic            done_o,
   output logic [7:0]      rbyte_o,
   // NAND pins
   output logic            cle_o,
   output logic            ale_o,
   output logic            we_n_o,
   output logic            re_n_o,
   output logic [7:0]      io_o,
   output logic            io_oe_n_o,
   input  wire logic [7:0] io_i
);
   import ncs_pkg::*;
   // kind: 0 command, 1 address, 2 data write, 3 data read
   logic [3:0] cnt_q;
   logic       act_q, ph_q;
   logic [7:0] rb_q;
   logic       rd_k;
   assign rd_k = (kind_i == 2'd3);
   assign done_o  = act_q & ph_q & (cnt_q == 4'(STROBE_CYC - 1));
   assign rbyte_o = rb_q;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         act_q <= 1'b0;
         ph_q <= 1'b0;
         cnt_q <= 4'h0;
         rb_q <= 8'h00;
         cle_o <= 1'b0;
         ale_o <= 1'b0;
         we_n_o <= 1'b1;
         re_n_o <= 1'b1;
         io_o <= 8'h00;
         io_oe_n_o <= 1'b1;
      end else if (!act_q) begin
         if (req_i) begin
            act_q <= 1'b1;
            ph_q <= 1'b0;
            cnt_q <= 4'h0;
            cle_o <= (kind_i == 2'd0);
            ale_o <= (kind_i == 2'd1);
            io_o <= byte_i;
            io_oe_n_o <= rd_k;
            we_n_o <= rd_k;
            re_n_o <= ~rd_k;
         end
      end else if (cnt_q != 4'(STROBE_CYC - 1)) begin
         cnt_q <= cnt_q + 4'h1;
      end else if (!ph_q) begin
         ph_q <= 1'b1;
         cnt_q <= 4'h0;
         if (!re_n_o) rb_q <= io_i;
         we_n_o <= 1'b1;
         re_n_o <= 1'b1;
      end else begin
         act_q <= 1'b0;
         cle_o <= 1'b0;
         ale_o <= 1'b0;
         io_oe_n_o <= 1'b1;
      end
   end
endmodule

// ===== ncs_nand_model.sv
`timescale 1ns/1ps
module ncs_nand_model #(
   parameter int ERASE_CYC = 40,
   parameter int PROG_CYC  = 30,
   parameter int REJ_CYC   = 6,
   parameter int FETCH_CYC = 12
) (
   // Clock and fault injection
   input  wire logic       sys_clk_i,
   input  wire logic       fail_i,
   // Flash pins
   input  wire logic       cle_i,
   input  wire logic       ale_i,
   input  wire logic       we_n_i,
   input  wire logic       re_n_i,
   input  wire logic [7:0] io_i,
   output logic      [7:0] io_o,
   output logic            rb_n_o
);
   logic [7:0]  adr [0:3];
   logic [7:0]  cache [0:4095];
   logic [7:0]  otp [0:11][0:15];
   logic [7:0]  mode = 8'h00;
   logic [7:0]  last_q = 8'h00;
   logic [9:0]  blk = 10'h000;
   logic [15:0] prog_row = 16'h0000;
   logic        prot = 1'b0;
   logic        wp = 1'b1;
   logic        fail_q = 1'b0;
   logic        smode = 1'b0;
   int          bcnt = 0;
   int          na = 0;
   int          nd = 0;
   wire logic [11:0] col = {adr[1][3:0], adr[0]};
   wire logic [7:0]  sbyte = {wp, rb_n_o, rb_n_o, 4'h0, fail_q & rb_n_o};
   initial begin
      foreach (adr[i]) adr[i] = 8'h00;
      foreach (cache[i]) cache[i] = 8'hFF;
      foreach (otp[i, j]) otp[i][j] = 8'hFF;
   end
   // Released bus shows the inverse of the last byte, never a stale copy
   assign rb_n_o = (bcnt == 0);
   assign io_o = re_n_i ? ~last_q : (smode ? sbyte : cache[col + nd]);
   always @(posedge re_n_i) begin
      last_q = smode ? sbyte : cache[col + nd];
      if (!smode) nd++;
   end
   always @(posedge sys_clk_i) begin
      if (bcnt > 0) bcnt = bcnt - 1;
   end
   always @(posedge we_n_i) begin
      if (cle_i) begin
         if (bcnt == 0 || io_i == 8'h70 || io_i == 8'hFF) begin
            smode = (io_i == 8'h70);
            case (io_i)
               8'h70: ;
               8'hFF: bcnt = 4;
               8'h35, 8'h30: begin
                  for (int i = 0; i < 4096; i++) cache[i] = adr[2] ^ i[7:0];
                  bcnt = FETCH_CYC;
               end
               8'hD0: begin
                  blk = 10'({adr[1], adr[0]} >> 6);
                  fail_q = fail_i;
                  bcnt = ERASE_CYC;
               end
               8'h10: begin
                  fail_q = fail_i;
                  wp = !(mode == 8'hA0 && prot);
                  bcnt = wp ? PROG_CYC : REJ_CYC;
                  if (mode == 8'hA5 && {adr[0], adr[1], adr[2], adr[3]} == 32'h0000_0100)
                     prot = 1'b1;
                  if (mode == 8'h00) prog_row = {adr[3], adr[2]};
               end
               8'h85: begin
                  na = 0;
                  nd = 0;
               end
               default: begin
                  mode = io_i;
                  na = 0;
                  nd = 0;
               end
            endcase
         end
      end else if (ale_i && bcnt == 0 && na < 4) begin
         adr[na] = io_i;
         na++;
      end else if (!ale_i && bcnt == 0) begin
         if (mode != 8'hA0) cache[col + nd] = io_i;
         else if (!prot && adr[2] >= 8'h02 && adr[2] <= 8'h0B && col < 16)
            otp[adr[2]][col[3:0]] &= io_i;
         nd++;
      end
   end
endmodule

// ===== tb_nand_copyback_erase_otp_cmds.sv
`timescale 1ns/1ps
module tb_nand_copyback_erase_otp_cmds;
   import ncs_pkg::*;
   logic        sys_clk_i = 0;
   logic        rst_i = 1;
   logic        psel_i = 0;
   logic        penable_i = 0;
   logic        pwrite_i = 0;
   logic        fail = 0;
   logic [7:0]  paddr_i = 0;
   logic [31:0] pwdata_i = 0;
   logic [31:0] prdata_o, r;
   logic        pready_o, pslverr_o, cle_o, ale_o, ce_n_o, we_n_o, re_n_o, io_oe_n_o;
   logic        rb_n, e;
   logic [7:0]  io_o, io_dev, pg, exp_otp;
   logic [7:0]  d [4];
   logic [15:0] row, row2;
   logic [11:0] col;
   int          n_fail = 0;
   int          num_checks = 0;
   wire logic [7:0] io_bus = !io_oe_n_o ? io_o : io_dev;
   ncs_top uut (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .cle_o, .ale_o, .ce_n_o, .we_n_o, .re_n_o, .io_o,
      .io_oe_n_o, .io_i(io_bus), .rb_n_i(rb_n));
   ncs_nand_model dev (.sys_clk_i, .fail_i(fail), .cle_i(cle_o), .ale_i(ale_o),
      .we_n_i(we_n_o), .re_n_i(re_n_o), .io_i(io_bus), .io_o(io_dev), .rb_n_o(rb_n));
   always #20 sys_clk_i = ~sys_clk_i;
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] exp_stat(input logic [7:0] sb);
      return {16'h0, sb, 5'h0, fail | ~sb[7], 2'b00};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge sys_clk_i);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge sys_clk_i);
      penable_i <= 1;
      k = 0;
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 100);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      if (pready_o !== 1'b1) begin
         n_fail++;
         results();
      end
   endtask
   task automatic wait_clear(input logic [31:0] m);
      int k;
      k = 0;
      do begin
         apb(0, REG_STAT, 0);
         k++;
      end while ((r & m) !== 32'h0 && k < 500);
      if (k >= 500) begin
         n_fail++;
         results();
      end
   endtask
   task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [11:0] n);
      apb(1, REG_ADDR, a);
      apb(1, REG_CTRL, {4'h0, n, 11'h0, 1'b1, 1'b0, op});
      for (int i = 0; i < n; i++) begin
         wait_clear(32'h2);
         apb(1, REG_DATA, {24'h0, d[i]});
      end
      wait_clear(32'h3);
   endtask
   initial begin
      void'($urandom(45589));
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 0;
      apb(0, 8'h20, 0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(0, REG_STAT, 0);
      chk(r, 32'h0);
      apb(0, REG_RDATA, 0);
      for (int i = 0; i < 4; i++) begin
         row = (i == 0) ? 16'hFFFF : 16'($urandom);
         fail <= 1'($urandom);
         run(OP_ERASE, {row, 16'h0}, 0);
         chk(dev.blk, row[15:6]);
         apb(0, REG_STAT, 0);
         chk(r & 32'h0000FF07, exp_stat({3'h7, 4'h0, fail}));
      end
      fail <= 0;
      row = 16'($urandom);
      row2 = {row[15], 15'($urandom)};
      col = 12'($urandom % 2048);
      d[0] = 8'($urandom);
      d[1] = 8'($urandom);
      run(OP_MOVE_RD, {row, 4'h0, col}, 0);
      chk(dev.cache[col + 3], row[7:0] ^ (col[7:0] + 8'h3));
      run(OP_COL_IN, {20'h0, col}, 1);
      d[0] = d[1];
      run(OP_COL_IN, {20'h0, col + 12'h1}, 1);
      run(OP_MOVE_PROG, {row2, 16'h0}, 0);
      chk(dev.cache[col + 1], d[1]);
      chk(dev.prog_row, row2);
      apb(0, REG_STAT, 0);
      chk(r & 32'h0000FF07, exp_stat(8'hE0));
      pg = 8'h02 + 8'($urandom % 10);
      col = 12'($urandom % 16);
      exp_otp = 8'hFF;
      repeat (2) begin
         d[0] = 8'($urandom);
         exp_otp &= d[0];
         run(OP_OTP_PROG, {8'h0, pg, 4'h0, col}, 1);
         apb(0, REG_STAT, 0);
         chk(r & 32'h0000FF07, exp_stat(8'hE0));
      end
      run(OP_OTP_PROG, {8'h0, 8'h0C, 4'h0, col}, 1);
      apb(0, REG_STAT, 0);
      chk(r & 32'h0000FF07, exp_stat(8'hE0) | 32'h4);
      chk(dev.otp[pg][col[3:0]], exp_otp);
      run(OP_OTP_PROT, 0, 0);
      chk(dev.prot, 1);
      d[0] = 8'h00;
      run(OP_OTP_PROG, {8'h0, pg, 4'h0, col}, 1);
      apb(0, REG_STAT, 0);
      chk(r & 32'h0000FF07, exp_stat(8'h60));
      chk(dev.otp[pg][col[3:0]], exp_otp);
      run(OP_OTP_READ, {8'h0, pg, 16'h0}, 1);
      chk(dev.cache[0], pg);
      apb(0, REG_RDATA, 0);
      chk(r, {24'h0, pg});
      run(OP_RESET, 0, 0);
      apb(0, REG_STAT, 0);
      chk(r & 32'h1, 32'h0);
      results();
   end
endmodule
